// ===== hdl/sw_act_pkg.sv
// Purpose: Constants for the software activation control block
// Assumes: Byte-wide registers on a plain strobe port
// Notes: Register offsets are local word indices
package sw_act_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int VEC_W = 7;
  localparam int VADDR_W = 16;
  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_SEL = 4'h1;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 4'h3;
  localparam logic [ADDR_W-1:0] OFS_VADDR_LO = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_VADDR_HI = 4'h5;
  // Field positions
  localparam int BIT_ENABLE = 7;
  localparam int BIT_SEL = 0;
  localparam int BIT_EVT_LAUNCH = 0;
  localparam int BIT_EVT_AUTOCLR = 1;
  localparam int BIT_EVT_END = 2;
  localparam int IRQ_W = 3;
  // Reset values and vector base
  localparam logic [VEC_W-1:0] VEC_RESET = 7'h00;
  localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;
  localparam logic [VADDR_W-1:0] VEC_BASE = 16'h0400;
  localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
  // Vector address: base plus twice the number
  function automatic logic [VADDR_W-1:0] vec_addr(
    input logic [VEC_W-1:0] num);
    vec_addr = VEC_BASE + {8'h00, num, 1'b0};
  endfunction
endpackage

// ===== hdl/transfer_sw_activation_ctrl.sv
// What this block does
// - Select 0 and count not ended: enable clears at activation end.
// - Writing select 0 after end interrupt raised clears enable.
// - Select 1 at end, or count ended: enable stays set.
// - Seven-bit vector number lives in bits 6 down to 0.
// - Vector address is base 0400 plus twice the vector number.
// - Vector field is writable only while enable reads 0.
//
// Purpose: Software activation control of a transfer controller
// Assumes: Engine reports activation end as a pulse, with count state valid beside it
// Notes: Byte registers, read data one cycle after read strobe
//
// Implementation choices: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module transfer_sw_activation_ctrl (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [sw_act_pkg::ADDR_W-1:0] addr_i,
  input wire logic [sw_act_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [sw_act_pkg::DATA_W-1:0] rdata_o,
  input wire logic act_done_i,
  input wire logic count_ended_i,
  output logic launch_o,
  output logic [sw_act_pkg::VADDR_W-1:0] vec_addr_o,
  output logic sw_transfer_end_irq_o,
  output logic irq_o
);
  import sw_act_pkg::*;

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  logic sw_activation_enable_ff;
  logic [VEC_W-1:0] sw_activation_vector_ff;
  logic per_transfer_interrupt_select_ff;
  logic end_irq_ff;
  logic [IRQ_W-1:0] irq_stat_ff;
  logic [IRQ_W-1:0] irq_mask_ff;
  logic wr_ctrl, wr_sel, auto_clr, sel_clr, evt_end;
  logic [IRQ_W-1:0] evt;

  assign wr_ctrl = wr_i && (addr_i == OFS_CTRL);
  assign wr_sel = wr_i && (addr_i == OFS_SEL);
  assign auto_clr = act_done_i && !per_transfer_interrupt_select_ff &&
                    !count_ended_i;
  assign sel_clr = wr_sel && !wdata_i[BIT_SEL] && end_irq_ff;
  // end with select 1 or count ended raises end interrupt, no clear
  assign evt_end = act_done_i && sw_activation_enable_ff &&
                   (per_transfer_interrupt_select_ff || count_ended_i);

  // ----------------------------------------
  // Enable bit
  // ----------------------------------------
  // write of 1 sets enable; a same-cycle write, of 0 or 1, beats the clears
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      sw_activation_enable_ff <= 1'b0;
    end else if (wr_ctrl) begin
      sw_activation_enable_ff <= wdata_i[BIT_ENABLE];
    end else if (auto_clr || sel_clr) begin
      sw_activation_enable_ff <= 1'b0;
    end
  end

  // Vector field, frozen while enabled so a running launch sees it stable
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      sw_activation_vector_ff <= VEC_RESET;
    end else if (wr_ctrl && !sw_activation_enable_ff) begin
      sw_activation_vector_ff <= wdata_i[VEC_W-1:0];
    end
  end

  // Per-transfer interrupt select
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      per_transfer_interrupt_select_ff <= 1'b0;
    end else if (wr_sel) begin
      per_transfer_interrupt_select_ff <= wdata_i[BIT_SEL];
    end
  end

  // End interrupt request to CPU; dropped with the select-0 clear
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      end_irq_ff <= 1'b0;
    end else if (evt_end) begin
      end_irq_ff <= 1'b1;
    end else if (sel_clr) begin
      end_irq_ff <= 1'b0;
    end
  end
  assign sw_transfer_end_irq_o = end_irq_ff;

  // ----------------------------------------
  // Launch and vector address
  // ----------------------------------------
  // one pulse per write of 1, none when enable written 0
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      launch_o <= 1'b0;
    end else begin
      launch_o <= wr_ctrl && wdata_i[BIT_ENABLE];
    end
  end

  // base plus twice vector, same-cycle write vector used on launch only while enable is 0
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      vec_addr_o <= VEC_BASE;
    end else if (wr_ctrl && !sw_activation_enable_ff) begin
      vec_addr_o <= vec_addr(wdata_i[VEC_W-1:0]);
    end else begin
      vec_addr_o <= vec_addr(sw_activation_vector_ff);
    end
  end

  // ----------------------------------------
  // Interrupt status and mask
  // ----------------------------------------
  assign evt[BIT_EVT_LAUNCH] = wr_ctrl && wdata_i[BIT_ENABLE];
  assign evt[BIT_EVT_AUTOCLR] = auto_clr && sw_activation_enable_ff;
  assign evt[BIT_EVT_END] = evt_end;

  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      irq_stat_ff <= IRQ_RESET;
    end else if (wr_i && addr_i == OFS_IRQ_STAT) begin
      irq_stat_ff <= (irq_stat_ff & ~wdata_i[IRQ_W-1:0]) | evt;
    end else begin
      irq_stat_ff <= irq_stat_ff | evt;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      irq_mask_ff <= IRQ_RESET;
    end else if (wr_i && addr_i == OFS_IRQ_MASK) begin
      irq_mask_ff <= wdata_i[IRQ_W-1:0];
    end
  end

  // Registered, so irq lags status by one cycle
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_stat_ff & irq_mask_ff);
    end
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  // Unmapped reads return zero; data valid only the cycle after strobe
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rdata_o <= ZERO_BYTE;
    end else if (rd_i) begin
      unique case (addr_i)
        OFS_CTRL: rdata_o <= {sw_activation_enable_ff,
                              sw_activation_vector_ff};
        OFS_SEL: rdata_o <= {{(DATA_W-1){1'b0}},
                             per_transfer_interrupt_select_ff};
        OFS_IRQ_STAT: rdata_o <= {{(DATA_W-IRQ_W){1'b0}}, irq_stat_ff};
        OFS_IRQ_MASK: rdata_o <= {{(DATA_W-IRQ_W){1'b0}}, irq_mask_ff};
        // High byte of the vector address sits at the next index
        OFS_VADDR_LO: rdata_o <= vec_addr_o[DATA_W-1:0];
        OFS_VADDR_HI: rdata_o <= vec_addr_o[VADDR_W-1:DATA_W];
        default: rdata_o <= ZERO_BYTE;
      endcase
    end else begin
      rdata_o <= ZERO_BYTE;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // write launches
  property p_launch;
    @(posedge core_clk_i) disable iff (rst_i)
    (wr_ctrl && wdata_i[BIT_ENABLE]) |=> launch_o && sw_activation_enable_ff;
  endproperty
  a_launch: assert property (p_launch)
    else $error("write of enable 1 did not launch");

  property p_no_launch;
    @(posedge core_clk_i) disable iff (rst_i)
    !(wr_ctrl && wdata_i[BIT_ENABLE]) |=> !launch_o;
  endproperty
  a_no_launch: assert property (p_no_launch)
    else $error("launch without enable write");

  property p_autoclr;
    @(posedge core_clk_i) disable iff (rst_i)
    (auto_clr && !wr_ctrl) |=> !sw_activation_enable_ff;
  endproperty
  a_autoclr: assert property (p_autoclr)
    else $error("enable not cleared at activation end");

  property p_selclr;
    @(posedge core_clk_i) disable iff (rst_i)
    (sel_clr && !wr_ctrl) |=> !sw_activation_enable_ff &&
      (!end_irq_ff || $past(evt_end));
  endproperty
  a_selclr: assert property (p_selclr)
    else $error("select 0 write did not clear enable");

  property p_keep;
    @(posedge core_clk_i) disable iff (rst_i)
    (sw_activation_enable_ff && !wr_ctrl && !sel_clr && evt_end)
      |=> sw_activation_enable_ff && end_irq_ff;
  endproperty
  a_keep: assert property (p_keep)
    else $error("enable dropped at counted end");

  property p_vaddr;
    @(posedge core_clk_i) disable iff (rst_i)
    !(wr_ctrl && !sw_activation_enable_ff) |=> vec_addr_o == VEC_BASE +
      {{(VADDR_W-VEC_W-1){1'b0}}, $past(sw_activation_vector_ff), 1'b0};
  endproperty
  a_vaddr: assert property (p_vaddr)
    else $error("vector address wrong");

  property p_vec_write;
    @(posedge core_clk_i) disable iff (rst_i)
    (wr_ctrl && !sw_activation_enable_ff)
      |=> sw_activation_vector_ff == $past(wdata_i[VEC_W-1:0]);
  endproperty
  a_vec_write: assert property (p_vec_write)
    else $error("vector field write lost");

  property p_vec_hold;
    @(posedge core_clk_i) disable iff (rst_i)
    sw_activation_enable_ff |=> $stable(sw_activation_vector_ff);
  endproperty
  a_vec_hold: assert property (p_vec_hold)
    else $error("vector changed while enabled");

  property p_vec_gate;
    @(posedge core_clk_i) disable iff (rst_i)
    $changed(sw_activation_vector_ff) |-> $past(!sw_activation_enable_ff);
  endproperty
  a_vec_gate: assert property (p_vec_gate)
    else $error("vector written while enable set");

  property p_vaddr_wr;
    @(posedge core_clk_i) disable iff (rst_i)
    (wr_ctrl && !sw_activation_enable_ff) |=> vec_addr_o ==
      VEC_BASE + {{(VADDR_W-VEC_W-1){1'b0}},
                  $past(wdata_i[VEC_W-1:0]), 1'b0};
  endproperty
  a_vaddr_wr: assert property (p_vaddr_wr)
    else $error("vector address ignores written vector");

  property p_sel_keep;
    @(posedge core_clk_i) disable iff (rst_i)
    (wr_sel && !wdata_i[BIT_SEL] && !end_irq_ff && !auto_clr &&
     sw_activation_enable_ff) |=> sw_activation_enable_ff;
  endproperty
  a_sel_keep: assert property (p_sel_keep)
    else $error("select 0 write cleared enable too early");

  property p_enable_hold;
    @(posedge core_clk_i) disable iff (rst_i)
    (!wr_ctrl && !auto_clr && !sel_clr) |=>
      $stable(sw_activation_enable_ff);
  endproperty
  a_enable_hold: assert property (p_enable_hold)
    else $error("enable changed with no cause");

  property p_stat_end;
    @(posedge core_clk_i) disable iff (rst_i)
    evt_end |=> irq_stat_ff[BIT_EVT_END] && end_irq_ff;
  endproperty
  a_stat_end: assert property (p_stat_end)
    else $error("end event not recorded");

  property p_stat_autoclr;
    @(posedge core_clk_i) disable iff (rst_i)
    (auto_clr && sw_activation_enable_ff) |=>
      irq_stat_ff[BIT_EVT_AUTOCLR];
  endproperty
  a_stat_autoclr: assert property (p_stat_autoclr)
    else $error("auto-clear event not recorded");

  property p_ctrl_read;
    @(posedge core_clk_i) disable iff (rst_i)
    (rd_i && addr_i == OFS_CTRL) |=>
      rdata_o == {$past(sw_activation_enable_ff),
                  $past(sw_activation_vector_ff)};
  endproperty
  a_ctrl_read: assert property (p_ctrl_read)
    else $error("control read data wrong");

endmodule // transfer_sw_activation_ctrl
`default_nettype wire

// ===== testbench/engine_model.sv
// Purpose: Transfer engine stand-in that answers each launch
// Assumes: One activation outstanding at a time
// Notes: Count state is meaningful only beside the done pulse
`timescale 1ns/1ps
`default_nettype none
module engine_model #(parameter int DLY = 3) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic launch_i,
  input wire logic ended_cfg_i,
  output logic act_done_o,
  output logic count_ended_o
);
  int cnt_ff;
  // Count down from a launch; a relaunch restarts the wait
  always_ff @(posedge core_clk_i) begin
    act_done_o <= 1'b0;
    if (rst_i) begin
      cnt_ff <= 0;
    end else if (launch_i) begin
      cnt_ff <= DLY;
    end else if (cnt_ff > 0) begin
      cnt_ff <= cnt_ff - 1;
      act_done_o <= (cnt_ff == 1);
    end
  end
  // Inverted away from done so a stray sample shows up
  assign count_ended_o = act_done_o ? ended_cfg_i : ~ended_cfg_i;
endmodule // engine_model
`default_nettype wire

// ===== testbench/transfer_sw_activation_ctrl_bench.sv
// Purpose: Register level test of the activation control
// Assumes: Engine model answers four cycles after the launch pulse
// Notes: Results sampled at the falling edge
`timescale 1ns/1ps
`default_nettype none
module transfer_sw_activation_ctrl_bench;
  import sw_act_pkg::*;
  logic core_clk_i, rst_i, wr_i, rd_i, ended_cfg;
  logic [ADDR_W-1:0] addr_i;
  logic [DATA_W-1:0] wdata_i, rdata_o;
  logic act_done, count_ended, launch_o, end_irq_o, irq_o;
  logic [VADDR_W-1:0] vec_addr_o;
  int errors = 0;
  int comparisons = 0;
  transfer_sw_activation_ctrl uut (.core_clk_i(core_clk_i),
    .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .act_done_i(act_done),
    .count_ended_i(count_ended), .launch_o(launch_o),
    .vec_addr_o(vec_addr_o), .sw_transfer_end_irq_o(end_irq_o),
    .irq_o(irq_o));
  engine_model #(.DLY(3)) eng (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .launch_i(launch_o), .ended_cfg_i(ended_cfg),
    .act_done_o(act_done), .count_ended_o(count_ended));
  // -------------------------------------------------------------------
  // Clock and access tasks
  // -------------------------------------------------------------------
  initial begin
    core_clk_i = 1'b0;
    forever #10 core_clk_i = ~core_clk_i;
  end
  task automatic chk(input string n, input logic [15:0] e,
                     input logic [15:0] s);
    comparisons++;
    if (s !== e) begin
      errors++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
  endtask
  // Data stand only in the cycle after the strobe
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] e);
    @(posedge core_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    @(negedge core_clk_i);
    chk("rdata", {8'h00, e}, {8'h00, rdata_o});
  endtask
  // Launch with a given select and count state, then let it finish
  task automatic run(input logic [7:0] sel, input logic ended);
    wr(OFS_SEL, sel);
    ended_cfg <= ended;
    wr(OFS_CTRL, 8'h90);
    @(negedge core_clk_i);
    chk("launch", 16'h0001, {15'h0000, launch_o});
    repeat (6) @(posedge core_clk_i);
  endtask
  task automatic conclude;
    if (errors == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Hang guard, far beyond the hundred or so cycles needed
  initial begin
    #50000;
    errors++;
    conclude();
  end
  // -------------------------------------------------------------------
  // Test sequence
  // -------------------------------------------------------------------
  initial begin
    {wr_i, rd_i, ended_cfg, addr_i, wdata_i} = '0;
    rst_i = 1'b1;
    repeat (5) @(posedge core_clk_i);
    rst_i <= 1'b0;
    rd(OFS_CTRL, 8'h00);
    rd(OFS_VADDR_HI, 8'h04);
    wr(OFS_CTRL, 8'h7F);
    @(negedge core_clk_i);
    chk("launch", 16'h0000, {15'h0000, launch_o});
    chk("vaddr", 16'h04FE, vec_addr_o);
    rd(OFS_CTRL, 8'h7F);
    run(8'h01, 1'b0);
    rd(OFS_CTRL, 8'h90);
    chk("end_irq", 16'h0001, {15'h0000, end_irq_o});
    rd(OFS_VADDR_LO, 8'h20);
    rd(OFS_VADDR_HI, 8'h04);
    // Vector write while enabled must not land
    wr(OFS_CTRL, 8'h85);
    repeat (6) @(posedge core_clk_i);
    chk("vaddr", 16'h0420, vec_addr_o);
    rd(OFS_CTRL, 8'h90);
    wr(OFS_SEL, 8'h00);
    rd(OFS_CTRL, 8'h10);
    chk("end_irq", 16'h0000, {15'h0000, end_irq_o});
    wr(OFS_IRQ_STAT, 8'h07);
    run(8'h00, 1'b0);
    rd(OFS_CTRL, 8'h10);
    rd(OFS_IRQ_STAT, 8'h03);
    chk("irq", 16'h0000, {15'h0000, irq_o});
    wr(OFS_IRQ_MASK, 8'h02);
    @(posedge core_clk_i);
    @(negedge core_clk_i);
    chk("irq", 16'h0001, {15'h0000, irq_o});
    wr(OFS_IRQ_STAT, 8'h02);
    @(posedge core_clk_i);
    @(negedge core_clk_i);
    chk("irq", 16'h0000, {15'h0000, irq_o});
    rd(OFS_IRQ_STAT, 8'h01);
    run(8'h00, 1'b1);
    rd(OFS_CTRL, 8'h90);
    wr(OFS_SEL, 8'h00);
    rd(OFS_CTRL, 8'h10);
    // Select 0 written before the end interrupt must not clear enable
    wr(OFS_CTRL, 8'h90);
    wr(OFS_SEL, 8'h00);
    rd(OFS_CTRL, 8'h90);
    repeat (6) @(posedge core_clk_i);
    chk("end_irq", 16'h0001, {15'h0000, end_irq_o});
    rd(OFS_CTRL, 8'h90);
    rd(4'hF, 8'h00);
    conclude();
  end
endmodule // transfer_sw_activation_ctrl_bench
`default_nettype wire
